// ---- rtl/dbe_top.v ----
// Purpose: Debug wire front end: reset mode choice, command decode
// Assumes: Reset cause flags valid while reset is held
// Notes:   Memory and register read data are sampled in the same cycle as strobe
`timescale 1ns/1ps
`include "dbe_map.vh"

module dbe_top (
    input  wire        i_core_clk,
    input  wire        i_resetn,
    input  wire        i_wire_in,
    output wire        o_wire_out,
    output wire        o_wire_oe,
    input  wire        i_rst_por,
    input  wire        i_rst_force,
    input  wire        i_cpu_lowpwr,
    input  wire [15:0] i_cpu_addr,
    input  wire        i_cpu_fetch,
    output reg         o_halted,
    output reg         o_wdog_disable,
    output reg         o_osc_keep,
    output reg         o_wake,
    output reg         o_step,
    output reg         o_force_reset,
    output wire        o_bkpt_hit,
    output reg  [15:0] o_mem_addr,
    output reg  [7:0]  o_mem_wdata,
    output reg         o_mem_wr,
    output reg         o_mem_rd,
    input  wire [7:0]  i_mem_rdata,
    output reg  [2:0]  o_reg_sel,
    output reg  [15:0] o_reg_wdata,
    output reg         o_reg_wr,
    output reg         o_reg_rd,
    input  wire [15:0] i_reg_rdata
);

    // ----------------------------------------------------------------
    // States
    // ----------------------------------------------------------------
    localparam ST_CMD  = 3'h0;
    localparam ST_ARG  = 3'h1;
    localparam ST_EXEC = 3'h2;
    localparam ST_WAIT = 3'h3;
    localparam ST_TX   = 3'h4;

    reg  [2:0]  st_r;
    reg  [2:0]  st_nxt;
    reg  [7:0]  cmd_r;
    reg  [23:0] sh_r;
    reg  [4:0]  left_r;
    reg  [4:0]  in_bits;
    reg  [4:0]  out_bits;
    reg         halt_only;
    reg         known;
    reg  [15:0] tx_r;
    reg  [4:0]  tx_left_r;
    reg         rd_mem_r;
    reg         exit_r;
    reg         por_r;
    reg         force_r;
    reg         halted_r;
    reg         en_r;
    reg         bkpt_en_r;
    reg         bkpt_wr_r;

    wire        rx_valid;
    wire        rx_bit;
    wire        tx_done;
    wire        timeout;
    wire        sync;
    wire [15:0] bkpt_addr;
    wire [7:0]  cmd_in = {cmd_r[6:0], rx_bit};
    wire [7:0]  status = {en_r, halted_r, bkpt_en_r, i_cpu_lowpwr, 4'h0};

    // ----------------------------------------------------------------
    // Bit engine and breakpoint
    // ----------------------------------------------------------------
    dbe_bit u_bit (
        .i_core_clk   (i_core_clk),
        .i_resetn     (i_resetn),
        .i_wire       (i_wire_in),
        .i_tx_en      (st_r == ST_TX),
        .i_tx_bit     (tx_r[15]),
        .o_rx_valid_r (rx_valid),
        .o_rx_bit_r   (rx_bit),
        .o_tx_done_r  (tx_done),
        .o_timeout_r  (timeout),
        .o_sync_r     (sync),
        .o_drv_r      (o_wire_out),
        .o_oe_r       (o_wire_oe)
    );

    dbe_bkpt u_bkpt (
        .i_core_clk (i_core_clk),
        .i_resetn   (i_resetn),
        .i_wr       (bkpt_wr_r),
        .i_wdata    (sh_r[15:0]),
        .i_en       (bkpt_en_r & ~halted_r),
        .i_addr     (i_cpu_addr),
        .i_fetch    (i_cpu_fetch),
        .o_addr_r   (bkpt_addr),
        .o_hit_r    (o_bkpt_hit)
    );

    // ----------------------------------------------------------------
    // Command shape decode
    // ----------------------------------------------------------------
    always @* begin
        in_bits   = 5'h00;
        out_bits  = 5'h00;
        halt_only = 1'b0;
        known     = 1'b1;
        if (cmd_in[7:3] == `DBE_CMD_WR_REG) begin
            in_bits   = 5'h10;
            halt_only = 1'b1;
        end else if (cmd_in[7:3] == `DBE_CMD_RD_REG) begin
            out_bits  = 5'h10;
            halt_only = 1'b1;
        end else begin
            case (cmd_in)
                `DBE_CMD_HALT:    in_bits  = 5'h00;
                `DBE_CMD_RESUME:  halt_only = 1'b1;
                `DBE_CMD_STEP:    halt_only = 1'b1;
                `DBE_CMD_RD_STAT: out_bits = 5'h08;
                `DBE_CMD_WR_CTRL: in_bits  = 5'h08;
                `DBE_CMD_RD_BYTE: begin
                    in_bits  = 5'h10;
                    out_bits = 5'h08;
                end
                `DBE_CMD_WR_BYTE: in_bits  = 5'h18;
                `DBE_CMD_RD_BKPT: out_bits = 5'h10;
                `DBE_CMD_WR_BKPT: in_bits  = 5'h10;
                default:          known    = 1'b0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Command sequencer
    // ----------------------------------------------------------------
    always @* begin
        st_nxt = st_r;
        case (st_r)
            ST_CMD: begin
                if (rx_valid && (left_r == 5'h01)) begin
                    if (!known || (halt_only && !halted_r)) begin
                        st_nxt = ST_CMD;
                    end else if (in_bits != 5'h00) begin
                        st_nxt = ST_ARG;
                    end else begin
                        st_nxt = ST_EXEC;
                    end
                end
            end
            ST_ARG: begin
                if (rx_valid && (left_r == 5'h01)) begin
                    st_nxt = ST_EXEC;
                end
            end
            ST_EXEC: begin
                if (rd_mem_r) begin
                    st_nxt = ST_WAIT;
                end else if (tx_left_r != 5'h00) begin
                    st_nxt = ST_TX;
                end else begin
                    st_nxt = ST_CMD;
                end
            end
            ST_WAIT: st_nxt = ST_TX;
            ST_TX: begin
                if (tx_done && (tx_left_r == 5'h01)) begin
                    st_nxt = ST_CMD;
                end
            end
            default: st_nxt = ST_CMD;
        endcase
        if (timeout || sync) begin
            st_nxt = ST_CMD;
        end
    end

    // ----------------------------------------------------------------
    // Reset exit mode choice
    // ----------------------------------------------------------------
    always @(posedge i_core_clk) begin
        if (!i_resetn) begin
            exit_r  <= 1'b1;
            por_r   <= i_rst_por;
            force_r <= i_rst_force;
        end else begin
            exit_r  <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Datapath and debug state
    // ----------------------------------------------------------------
    always @(posedge i_core_clk) begin
        if (!i_resetn) begin
            st_r        <= ST_CMD;
            cmd_r       <= 8'h00;
            sh_r        <= 24'h000000;
            left_r      <= 5'h08;
            tx_r        <= 16'h0000;
            tx_left_r   <= 5'h00;
            rd_mem_r    <= 1'b0;
            halted_r    <= 1'b0;
            en_r        <= 1'b0;
            bkpt_en_r   <= 1'b0;
            bkpt_wr_r   <= 1'b0;
            o_wake      <= 1'b0;
            o_step      <= 1'b0;
            o_force_reset <= 1'b0;
            o_mem_addr  <= 16'h0000;
            o_mem_wdata <= 8'h00;
            o_mem_wr    <= 1'b0;
            o_mem_rd    <= 1'b0;
            o_reg_sel   <= 3'h0;
            o_reg_wdata <= 16'h0000;
            o_reg_wr    <= 1'b0;
            o_reg_rd    <= 1'b0;
        end else begin
            st_r          <= st_nxt;
            o_wake        <= 1'b0;
            o_step        <= 1'b0;
            o_force_reset <= 1'b0;
            o_mem_wr      <= 1'b0;
            o_mem_rd      <= 1'b0;
            o_reg_wr      <= 1'b0;
            o_reg_rd      <= 1'b0;
            bkpt_wr_r     <= 1'b0;
            if (exit_r) begin
                // Idle pulled-high wire or a pin/error reset gives user mode
                halted_r <= (por_r | force_r) & ~i_wire_in;
                en_r     <= (por_r | force_r) & ~i_wire_in;
            end else if (o_bkpt_hit) begin
                halted_r <= 1'b1;
            end
            if (timeout || sync) begin
                left_r <= 5'h08;
            end else begin
                case (st_r)
                    ST_CMD: begin
                        if (rx_valid) begin
                            cmd_r  <= cmd_in;
                            left_r <= (left_r == 5'h01) ? in_bits : left_r - 5'h01;
                            if (left_r == 5'h01) begin
                                tx_left_r <= out_bits;
                                if (in_bits == 5'h00) begin
                                    left_r <= 5'h08;
                                end
                            end
                        end
                    end
                    ST_ARG: begin
                        if (rx_valid) begin
                            sh_r   <= {sh_r[22:0], rx_bit};
                            left_r <= (left_r == 5'h01) ? 5'h08 : left_r - 5'h01;
                        end
                    end
                    ST_EXEC: begin
                        rd_mem_r <= 1'b0;
                        if (cmd_r[7:3] == `DBE_CMD_WR_REG) begin
                            o_reg_sel   <= cmd_r[2:0];
                            o_reg_wdata <= sh_r[15:0];
                            o_reg_wr    <= 1'b1;
                        end else if (cmd_r[7:3] == `DBE_CMD_RD_REG) begin
                            o_reg_sel <= cmd_r[2:0];
                            o_reg_rd  <= 1'b1;
                        end else begin
                            case (cmd_r)
                                `DBE_CMD_HALT: begin
                                    halted_r <= 1'b1;
                                    o_wake   <= i_cpu_lowpwr;
                                end
                                `DBE_CMD_RESUME: halted_r <= 1'b0;
                                `DBE_CMD_STEP:   o_step   <= 1'b1;
                                `DBE_CMD_RD_STAT: tx_r <= {status, 8'h00};
                                `DBE_CMD_WR_CTRL: begin
                                    en_r          <= sh_r[`DBE_CTL_ENABLE];
                                    bkpt_en_r     <= sh_r[`DBE_CTL_BKPT_EN];
                                    o_force_reset <= sh_r[`DBE_CTL_FORCE];
                                end
                                `DBE_CMD_RD_BYTE: begin
                                    o_mem_addr <= sh_r[15:0];
                                    o_mem_rd   <= 1'b1;
                                end
                                `DBE_CMD_WR_BYTE: begin
                                    o_mem_addr  <= sh_r[23:8];
                                    o_mem_wdata <= sh_r[7:0];
                                    o_mem_wr    <= 1'b1;
                                end
                                `DBE_CMD_RD_BKPT: tx_r      <= bkpt_addr;
                                `DBE_CMD_WR_BKPT: bkpt_wr_r <= 1'b1;
                                default: tx_r <= tx_r;
                            endcase
                        end
                    end
                    ST_WAIT: begin
                        if (cmd_r == `DBE_CMD_RD_BYTE) begin
                            tx_r <= {i_mem_rdata, 8'h00};
                        end else begin
                            tx_r <= i_reg_rdata;
                        end
                    end
                    ST_TX: begin
                        if (tx_done) begin
                            tx_r      <= {tx_r[14:0], 1'b0};
                            tx_left_r <= tx_left_r - 5'h01;
                        end
                    end
                    default: left_r <= 5'h08;
                endcase
            end
            if (st_nxt == ST_EXEC) begin
                rd_mem_r <= (cmd_in == `DBE_CMD_RD_BYTE) ||
                            (cmd_in[7:3] == `DBE_CMD_RD_REG) ||
                            ((st_r == ST_ARG) && (cmd_r == `DBE_CMD_RD_BYTE));
            end
        end
    end

    // ----------------------------------------------------------------
    // Side effects of debug state
    // ----------------------------------------------------------------
    always @(posedge i_core_clk) begin
        if (!i_resetn) begin
            o_halted       <= 1'b0;
            o_wdog_disable <= 1'b0;
            o_osc_keep     <= 1'b0;
        end else begin
            o_halted       <= halted_r;
            o_wdog_disable <= halted_r;
            o_osc_keep     <= en_r;
        end
    end

endmodule // dbe_top

// ---- rtl/dbe_map.vh ----
// Purpose: Constants for the single-wire debug entry front end
// Assumes: The core clock is the debug clock, one bit time is 16 cycles
// Notes:   All counts are in debug clock cycles
//
// How it works
// - Power-on reset with wire low enters halted mode
// - Forced reset with wire low enters halted mode
// - Pin or error resets always start user mode
// - Idle high wire means normal mode after reset
// - Halted-class commands accepted only while halted
// - Halted commands: register access, step, resume
// - Non-intrusive commands run at any time
// - Non-intrusive: memory and own status/control access
// - Own registers only reachable through wire commands
// - Sync command reveals communication rate
// - Halt request wakes processor from stop/wait
// - One hardware address breakpoint comparator
// - Oscillator kept running in stop when enabled
// - Watchdog held disabled while halted
// - MSB first, 16 cycles per bit
// - 512 idle cycles abort pending command harmlessly
// - Received bit sampled ten cycles after start
`ifndef DBE_MAP_VH
`define DBE_MAP_VH

// ----------------------------------------------------------------
// Bit timing
// ----------------------------------------------------------------
`define DBE_BIT_LAST     4'hf
`define DBE_RX_SAMPLE    4'ha
`define DBE_TX1_SPEEDUP  4'h7
`define DBE_TX0_LOW_END  4'hd
`define DBE_TIMEOUT      10'h200
`define DBE_SYNC_MIN     8'h80
`define DBE_SYNC_DLY     8'h10
`define DBE_SYNC_PULSE   8'h80

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define DBE_CMD_HALT     8'h90
`define DBE_CMD_RESUME   8'h08
`define DBE_CMD_STEP     8'h10
`define DBE_CMD_RD_STAT  8'he4
`define DBE_CMD_WR_CTRL  8'hc4
`define DBE_CMD_RD_BYTE  8'he0
`define DBE_CMD_WR_BYTE  8'hc0
`define DBE_CMD_RD_BKPT  8'he2
`define DBE_CMD_WR_BKPT  8'hc2
`define DBE_CMD_WR_REG   5'h08
`define DBE_CMD_RD_REG   5'h0c

// ----------------------------------------------------------------
// Status and control fields
// ----------------------------------------------------------------
`define DBE_CTL_ENABLE   7
`define DBE_CTL_HALTED   6
`define DBE_CTL_BKPT_EN  5
`define DBE_CTL_LOWPWR   4
`define DBE_CTL_FORCE    0
`define DBE_BKPT_RESET   16'hffff

`endif

// ---- rtl/dbe_bkpt.v ----
// Purpose: Single address breakpoint comparator
// Assumes: Fetch strobe and address valid in same cycle
// Notes:   Hit is a registered one-cycle pulse
`timescale 1ns/1ps
`include "dbe_map.vh"

module dbe_bkpt (
    input  wire        i_core_clk,
    input  wire        i_resetn,
    input  wire        i_wr,
    input  wire [15:0] i_wdata,
    input  wire        i_en,
    input  wire [15:0] i_addr,
    input  wire        i_fetch,
    output reg  [15:0] o_addr_r,
    output reg         o_hit_r
);

    always @(posedge i_core_clk) begin
        if (!i_resetn) begin
            o_addr_r <= `DBE_BKPT_RESET;
            o_hit_r  <= 1'b0;
        end else begin
            if (i_wr) begin
                o_addr_r <= i_wdata;
            end
            o_hit_r <= i_en & i_fetch & (i_addr == o_addr_r);
        end
    end

endmodule // dbe_bkpt

// ---- rtl/dbe_bit.v ----
// Purpose: Bit-level engine for the single debug wire
// Assumes: Wire input already synchronous to the core clock
// Notes:   Reports received bits, sent bits, timeout and sync
`timescale 1ns/1ps
`include "dbe_map.vh"

module dbe_bit (
    input  wire i_core_clk,
    input  wire i_resetn,
    input  wire i_wire,
    input  wire i_tx_en,
    input  wire i_tx_bit,
    output reg  o_rx_valid_r,
    output reg  o_rx_bit_r,
    output reg  o_tx_done_r,
    output reg  o_timeout_r,
    output reg  o_sync_r,
    output reg  o_drv_r,
    output reg  o_oe_r
);

    reg       wire_d_r;
    reg       busy_r;
    reg       txm_r;
    reg       txb_r;
    reg [3:0] cnt_r;
    reg [9:0] idle_r;
    reg [7:0] low_r;
    reg [1:0] sph_r;
    reg [7:0] scnt_r;

    wire fall = wire_d_r & ~i_wire;
    wire rise = ~wire_d_r & i_wire;

    always @(posedge i_core_clk) begin
        if (!i_resetn) begin
            wire_d_r     <= i_wire;
            busy_r       <= 1'b0;
            txm_r        <= 1'b0;
            txb_r        <= 1'b0;
            cnt_r        <= 4'h0;
            idle_r       <= 10'h000;
            low_r        <= 8'h00;
            sph_r        <= 2'h0;
            scnt_r       <= 8'h00;
            o_rx_valid_r <= 1'b0;
            o_rx_bit_r   <= 1'b0;
            o_tx_done_r  <= 1'b0;
            o_timeout_r  <= 1'b0;
            o_sync_r     <= 1'b0;
            o_drv_r      <= 1'b0;
            o_oe_r       <= 1'b0;
        end else begin
            wire_d_r     <= i_wire;
            o_rx_valid_r <= 1'b0;
            o_tx_done_r  <= 1'b0;
            o_sync_r     <= 1'b0;
            o_oe_r       <= 1'b0;
            o_drv_r      <= 1'b0;
            low_r        <= (i_wire | o_oe_r) ? 8'h00 : ((low_r == 8'hff) ? low_r : low_r + 8'h01);
            if (fall) begin
                idle_r <= 10'h000;
            end else if (idle_r != `DBE_TIMEOUT) begin
                idle_r <= idle_r + 10'h001;
            end
            o_timeout_r <= (idle_r == `DBE_TIMEOUT - 10'h001);
            // --------------------------------------------------------
            // Sync response, bit handling
            // --------------------------------------------------------
            if (sph_r != 2'h0) begin
                case (sph_r)
                    2'h1: begin
                        scnt_r <= scnt_r + 8'h01;
                        if (scnt_r == `DBE_SYNC_DLY - 8'h01) begin
                            sph_r  <= 2'h2;
                            scnt_r <= 8'h00;
                        end
                    end
                    2'h2: begin
                        o_oe_r <= 1'b1;
                        scnt_r <= scnt_r + 8'h01;
                        if (scnt_r == `DBE_SYNC_PULSE - 8'h01) begin
                            sph_r <= 2'h3;
                        end
                    end
                    default: begin
                        o_oe_r  <= 1'b1;
                        o_drv_r <= 1'b1;
                        sph_r   <= 2'h0;
                    end
                endcase
            end else if (rise && (low_r >= `DBE_SYNC_MIN)) begin
                sph_r    <= 2'h1;
                scnt_r   <= 8'h00;
                busy_r   <= 1'b0;
                o_sync_r <= 1'b1;
            end else if (busy_r) begin
                cnt_r <= cnt_r + 4'h1;
                if (txm_r && txb_r) begin
                    o_oe_r  <= (cnt_r == `DBE_TX1_SPEEDUP);
                    o_drv_r <= 1'b1;
                end else if (txm_r) begin
                    o_oe_r  <= (cnt_r <= `DBE_TX0_LOW_END);
                    o_drv_r <= (cnt_r == `DBE_TX0_LOW_END);
                end
                if (!txm_r && (cnt_r == `DBE_RX_SAMPLE)) begin
                    o_rx_valid_r <= 1'b1;
                    o_rx_bit_r   <= i_wire;
                end
                if (cnt_r == `DBE_BIT_LAST) begin
                    busy_r      <= 1'b0;
                    o_tx_done_r <= txm_r;
                end
            end else if (fall) begin
                busy_r <= 1'b1;
                cnt_r  <= 4'h0;
                txm_r  <= i_tx_en;
                txb_r  <= i_tx_bit;
            end
        end
    end

endmodule // dbe_bit

// ---- testbench/dbe_top_monitor.sv ----
// Purpose: Port assertions for the debug wire front end
// Assumes: One core clock domain, synchronous active-low reset
// Notes:   Attached to dbe_top by bind
`timescale 1ns/1ps
module dbe_top_mon (
    input wire i_core_clk, i_resetn, i_wire_in, o_wire_out, o_wire_oe,
    input wire i_rst_por, i_rst_force, i_cpu_lowpwr, o_halted, o_wdog_disable,
    input wire o_osc_keep, o_wake, o_step, o_reg_wr, o_reg_rd
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);
    // ----------------------------------------------------------------
    // Reset exit and link checks
    // ----------------------------------------------------------------
    sequence s_exit_low;
        $rose(i_resetn) && !i_wire_in;
    endsequence
    sequence s_tx0_start;
        o_wire_oe && !o_wire_out && !$past(o_wire_oe);
    endsequence
    a_por_entry: assert property (s_exit_low ##0 i_rst_por |-> ##[1:2] o_halted)
        else $error("power-on entry to halted missed");
    a_force_entry: assert property (s_exit_low ##0 i_rst_force |-> ##[1:2] o_halted)
        else $error("forced entry to halted missed");
    a_pin_reset: assert property (s_exit_low ##0 !i_rst_por && !i_rst_force |=> !o_halted [*2])
        else $error("pin reset entered halted");
    a_wire_high: assert property ($rose(i_resetn) && i_wire_in |=> !o_halted [*2])
        else $error("idle wire entered halted");
    a_osc_keep: assert property (s_exit_low ##0 i_rst_por |-> ##[1:3] o_osc_keep)
        else $error("oscillator hold not set");
    a_wdog_halted: assert property (o_wdog_disable == o_halted)
        else $error("watchdog hold differs from halted");
    a_halted_only: assert property (o_step || o_reg_wr || o_reg_rd |-> o_halted)
        else $error("halted command ran while running");
    a_step_pulse: assert property (o_step |=> !o_step)
        else $error("step pulse too long");
    a_wake_lowpwr: assert property (o_wake |-> i_cpu_lowpwr)
        else $error("wake without low power");
    a_tx0_low: assert property (s_tx0_start |-> (o_wire_oe && !o_wire_out) [*8])
        else $error("zero bit released early");
endmodule // dbe_top_mon
bind dbe_top dbe_top_mon u_mon (.i_core_clk, .i_resetn, .i_wire_in, .o_wire_out, .o_wire_oe, .i_rst_por,
    .i_rst_force, .i_cpu_lowpwr, .o_halted, .o_wdog_disable, .o_osc_keep, .o_wake, .o_step, .o_reg_wr, .o_reg_rd);

// ---- testbench/dbe_pod.sv ----
// Purpose: Host pod model driving the debug wire
// Assumes: Wire idles high through a pull-up
// Notes:   o_low pulls the wire low; bits are 19 cycles apart
`timescale 1ns/1ps
module dbe_pod (
    input  wire i_core_clk,
    input  wire i_wire,
    output reg  o_low
);
    initial o_low = 1'b0;
    task automatic send_bit(input logic b);
        @(negedge i_core_clk) o_low = 1'b1;
        repeat (b ? 2 : 12) @(negedge i_core_clk);
        o_low = 1'b0;
        repeat (b ? 16 : 6) @(negedge i_core_clk);
    endtask
    task automatic put8(input logic [7:0] v);
        for (int i = 7; i >= 0; i--) send_bit(v[i]);
    endtask
    task automatic put16(input logic [15:0] v);
        put8(v[15:8]);
        put8(v[7:0]);
    endtask
    task automatic get(output logic [15:0] v, input int n);
        v = 16'h0000;
        repeat (n) begin
            @(negedge i_core_clk) o_low = 1'b1;
            repeat (2) @(negedge i_core_clk);
            o_low = 1'b0;
            repeat (7) @(negedge i_core_clk);
            v = {v[14:0], i_wire};
            repeat (9) @(negedge i_core_clk);
        end
    endtask
endmodule // dbe_pod

// ---- testbench/dbe_top_tb.sv ----
// Purpose: Self-checking bench for the debug wire front end
// Assumes: Pod model is the only host on the wire
// Notes:   Strobes are scored against a queue of expected notes
`timescale 1ns/1ps
module dbe_top_tb;
    logic clk = 0, rstn = 0, por = 0, frc = 0, lp = 0, fe = 0;
    logic [7:0] mrd = 8'h00;
    logic [15:0] rrd = 16'h0000, v, a, d;
    logic [31:0] seed = 32'd77836, q[$];
    int mismatches = 0, check_count = 0, cyc = 0;
    wire wo, woe, hlt, wdd, osc, wk, stp, mw, mr, rw, rr, plow, fr, bh;
    wire [15:0] ma, rwd;
    wire [7:0] mwd;
    wire [2:0] rs;
    wire wl = ~(plow | (woe & ~wo));
    dbe_pod pod (.i_core_clk(clk), .i_wire(wl), .o_low(plow));
    dbe_top dut (.i_core_clk(clk), .i_resetn(rstn), .i_wire_in(wl), .o_wire_out(wo), .o_wire_oe(woe),
        .i_rst_por(por), .i_rst_force(frc), .i_cpu_lowpwr(lp), .i_cpu_addr(a), .i_cpu_fetch(fe),
        .o_halted(hlt), .o_wdog_disable(wdd), .o_osc_keep(osc), .o_wake(wk), .o_step(stp),
        .o_force_reset(fr), .o_bkpt_hit(bh), .o_mem_addr(ma), .o_mem_wdata(mwd), .o_mem_wr(mw), .o_mem_rd(mr),
        .i_mem_rdata(mrd), .o_reg_sel(rs), .o_reg_wdata(rwd), .o_reg_wr(rw), .o_reg_rd(rr), .i_reg_rdata(rrd));
    initial begin
        forever #10 clk = ~clk;
    end
    function automatic logic [31:0] rnd;
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input string n, input logic [31:0] s, e);
        check_count++;
        if (s !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic take(input string n, input logic [31:0] s);
        chk(n, s, q.size() > 0 ? q.pop_front() : 32'hxxxxxxxx);
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Reset with a chosen cause, wire held low or high past the exit edge
    task automatic boot(input logic p, f, lo, exp);
        @(negedge clk) rstn = 0;
        por = p;
        frc = f;
        pod.o_low = lo;
        repeat (6) @(negedge clk);
        rstn = 1;
        repeat (2) @(negedge clk);
        pod.o_low = 0;
        repeat (4) @(negedge clk);
        chk("halted", 32'(hlt), 32'(exp));
        chk("wdog", 32'(wdd), 32'(exp));
    endtask
    // ----------------------------------------------------------------
    // Scoreboard
    // ----------------------------------------------------------------
    always @(negedge clk) begin
        if (mw) take("mem_wr", {8'h01, ma, mwd});
        if (mr) take("mem_rd", {8'h02, 8'h00, ma});
        if (rw) take("reg_wr", {5'h00, rs, 8'h03, rwd});
        if (stp) take("step", 32'h04);
        if (wk) take("wake", 32'h05);
        if (fr) take("force", 32'h06);
        if (bh) take("hit", 32'h07);
    end
    always @(posedge clk) begin
        if (++cyc == 20000) begin
            mismatches++;
            conclude();
        end
    end
    initial begin
        boot(1, 0, 1, 1);
        pod.put8(8'he4);
        pod.get(v, 8);
        chk("status", 32'(v), 32'h00c0);
        d = rnd();
        a = rnd() & 16'h0007;
        rrd = rnd();
        q.push_back({5'h00, a[2:0], 8'h03, d});
        pod.put8({5'h08, a[2:0]});
        pod.put16(d);
        pod.put8({5'h0c, a[2:0]});
        pod.get(v, 16);
        chk("reg_rd", 32'(v), 32'(rrd));
        q.push_back(32'h04);
        pod.put8(8'h10);
        pod.put8(8'h08);
        chk("resumed", 32'(hlt), 32'h0);
        pod.put8(8'h10);
        a = rnd();
        d = rnd() & 16'h00ff;
        mrd = rnd();
        q.push_back({8'h01, a, d[7:0]});
        pod.put8(8'hc0);
        pod.put16(a);
        pod.put8(d[7:0]);
        q.push_back({8'h02, 8'h00, a});
        pod.put8(8'he0);
        pod.put16(a);
        pod.get(v, 8);
        chk("mem_rd", 32'(v), 32'(mrd));
        pod.put8(8'hc0);
        pod.put8(8'h12);
        repeat (600) @(negedge clk);
        lp = 1;
        q.push_back(32'h05);
        pod.put8(8'h90);
        chk("woken", 32'(hlt), 32'h1);
        chk("queue", 32'(q.size()), 32'h0);
        lp = 0;
        pod.put8(8'hc2);
        pod.put16(a);
        pod.put8(8'he2);
        pod.get(v, 16);
        chk("bkpt", 32'(v), 32'(a));
        q.push_back(32'h06);
        q.push_back(32'h07);
        pod.put8(8'hc4);
        pod.put8(8'ha1);
        pod.put8(8'h08);
        @(negedge clk) fe = 1;
        repeat (4) @(negedge clk) fe = 0;
        chk("bkpt_halt", 32'(hlt), 32'h1);
        pod.o_low = 1;
        repeat (130) @(negedge clk);
        pod.o_low = 0;
        repeat (40) @(negedge clk);
        chk("sync_low", 32'(wl), 32'h0);
        repeat (120) @(negedge clk);
        chk("sync_end", 32'(wl), 32'h1);
        boot(0, 0, 1, 0);
        boot(1, 0, 0, 0);
        boot(0, 1, 1, 1);
        conclude();
    end
endmodule // dbe_top_tb
